// ==== logic/ddr2_command_input_capture.sv ====
// Behaviour
// - Chip select high masks every command
// - Chip select gates the command, not part of its code
// - Decode row, column, write strobes as command
// - Fully masked write beats are not stored
// - Masks sampled on both strobe edges
// - Address and control sampled on rising crossing
// - Read data on both clock crossings
// - Clock enable gates internal clocking
// - Lower strobe/mask bits 0-7, upper 8-15

`default_nettype none

`include "cmd_capture_map.svh"

module ddr2_command_input_capture
    import cmd_capture_pkg::*;
(
    // System clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               rst_b_i,
    // Differential link clock and clock enable
    input  wire logic               ck_i,
    input  wire logic               ck_n_i,
    input  wire logic               cke_i,
    // Command and address pins
    input  wire logic               cs_n_i,
    input  wire logic               ras_n_i,
    input  wire logic               cas_n_i,
    input  wire logic               we_n_i,
    input  wire logic [2:0]         bank_i,
    input  wire logic [12:0]        addr_i,
    // Data pins, split into input, output and enable
    input  wire logic [15:0]        dq_i,
    output logic      [15:0]        dq_o,
    output logic                    dq_oe_o,
    // Byte strobes and masks
    input  wire logic               lstrobe_i,
    input  wire logic               ustrobe_i,
    output logic                    strobe_o,
    output logic                    strobe_oe_o,
    input  wire logic               lmask_i,
    input  wire logic               umask_i,
    // Captured command stream
    output logic                    cmd_valid_o,
    output cmd_word_t               cmd_o,
    output logic                    clk_active_o,
    // Captured write beats
    output logic                    beat_valid_o,
    input  wire logic               beat_ready_i,
    output beat_t                   beat_o,
    output logic                    beat_room_o,
    // Read words to send
    input  wire logic               rd_valid_i,
    output logic                    rd_ready_o,
    input  wire logic [31:0]        rd_word_i
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [`PIN_W-1:0] pin_raw;     // All pins, gathered
    logic [`PIN_W-1:0] pin_s1_r;    // First stage, read only by second
    logic [`PIN_W-1:0] pin_s2_r;    // Safe copy for all logic
    logic              lstrobe_q_r; // Previous lower strobe level
    logic              ustrobe_q_r; // Previous upper strobe level
    logic              cross_q_r;   // Previous clock phase

    assign pin_raw = {umask_i, lmask_i, ustrobe_i, lstrobe_i, dq_i,
                      addr_i, bank_i, cke_i, we_n_i, cas_n_i, ras_n_i,
                      cs_n_i, ck_n_i, ck_i};

    // Two flops on every pin, since they all come from the link
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Crossing detection
    // ----------------------------------------------------------------
    logic cross_hi;   // True clock high and complement low
    logic rise_x;     // Rising crossing seen this cycle
    logic fall_x;     // Falling crossing seen this cycle

    // Both legs must agree, so a glitch on one leg is no crossing
    assign cross_hi = pin_s2_r[`PIN_CK] & ~pin_s2_r[`PIN_CK_N];
    assign rise_x   = cross_hi & ~cross_q_r;
    assign fall_x   = ~pin_s2_r[`PIN_CK] & pin_s2_r[`PIN_CK_N] & cross_q_r;

    // Previous phase and strobe levels for edge finding
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cross_q_r   <= 1'b0;
            lstrobe_q_r <= 1'b0;
            ustrobe_q_r <= 1'b0;
        end else begin
            if (rise_x) begin
                cross_q_r <= 1'b1;
            end else if (fall_x) begin
                cross_q_r <= 1'b0;
            end
            lstrobe_q_r <= pin_s2_r[`PIN_LSTROBE];
            ustrobe_q_r <= pin_s2_r[`PIN_USTROBE];
        end
    end

    // ----------------------------------------------------------------
    // Clock enable
    // ----------------------------------------------------------------
    logic clk_en_r;   // Internal clocking running

    // Registered only on a rising crossing
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_en_r <= 1'b0;
        end else if (rise_x) begin
            clk_en_r <= pin_s2_r[`PIN_CKE];
        end
    end

    assign clk_active_o = clk_en_r;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    cmd_code_t code_nxt;   // Decoded code of the sampled lines
    logic      take_cmd;   // A command is really presented

    // Row, column and write strobes as one three-bit code
    always_comb begin
        case ({pin_s2_r[`PIN_RAS_N], pin_s2_r[`PIN_CAS_N], pin_s2_r[`PIN_WE_N]})
            3'h0:    code_nxt = CMD_MRS;
            3'h1:    code_nxt = CMD_REF;
            3'h2:    code_nxt = CMD_PRE;
            3'h3:    code_nxt = CMD_ACT;
            3'h4:    code_nxt = CMD_WR;
            3'h5:    code_nxt = CMD_RD;
            3'h6:    code_nxt = CMD_RSVD;
            default: code_nxt = CMD_NOP;
        endcase
    end

    // Chip select low qualifies the command, outside the code; high masks it
    assign take_cmd = rise_x & clk_en_r & ~pin_s2_r[`PIN_CS_N];

    // Command word, held until the next one; valid is one pulse
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o       <= '{code: CMD_NOP, bank: 3'h0, addr: 13'h0};
        end else begin
            cmd_valid_o <= take_cmd;
            if (take_cmd) begin
                cmd_o.code <= code_nxt;
                cmd_o.bank <= pin_s2_r[`PIN_BA_LO +: `BANK_W];
                cmd_o.addr <= pin_s2_r[`PIN_ADDR_LO +: `ADDR_W];
            end
        end
    end

    // ----------------------------------------------------------------
    // Write window
    // ----------------------------------------------------------------
    logic [3:0] wr_win_r;   // Link periods left for write beats

    // Opened by a write, counted down on rising crossings
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_win_r <= 4'h0;
        end else if (take_cmd && code_nxt == CMD_WR) begin
            wr_win_r <= `WR_WINDOW_CLKS;
        end else if (rise_x && wr_win_r != 4'h0) begin
            wr_win_r <= wr_win_r - 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Write beat capture
    // ----------------------------------------------------------------
    logic  l_edge;      // Lower strobe changed level
    logic  u_edge;      // Upper strobe changed level
    logic  beat_push;   // A beat offered to the buffer
    beat_t beat_in;     // The beat itself
    logic  buf_ready;   // Buffer has room

    // Either strobe direction is a beat, which gives double rate
    assign l_edge = pin_s2_r[`PIN_LSTROBE] ^ lstrobe_q_r;
    assign u_edge = pin_s2_r[`PIN_USTROBE] ^ ustrobe_q_r;

    // Each byte lane follows its own strobe and mask
    assign beat_in.data    = pin_s2_r[`PIN_DQ_LO +: `DQ_W];
    assign beat_in.byte_en = {u_edge & ~pin_s2_r[`PIN_UMASK],
                              l_edge & ~pin_s2_r[`PIN_LMASK]};

    // Only inside a write, with clocks on and the bus not driven;
    // a beat with both lanes masked is dropped whole
    assign beat_push = clk_en_r & (wr_win_r != 4'h0) & ~dq_oe_o
                     & (beat_in.byte_en != 2'b00);

    // A beat the buffer cannot take is shown to the user as no room,
    // because the link itself cannot be stalled
    assign beat_room_o = buf_ready;

    pair_buffer u_beat_buf (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (beat_push),
        .in_ready_o  (buf_ready),
        .in_beat_i   (beat_in),
        .out_valid_o (beat_valid_o),
        .out_ready_i (beat_ready_i),
        .out_beat_o  (beat_o)
    );

    // ----------------------------------------------------------------
    // Read data drive
    // ----------------------------------------------------------------
    logic [15:0] hi_half_r;   // Second beat waiting for the fall

    // A word is taken only at a rising crossing with clocks on
    assign rd_ready_o = rise_x & clk_en_r;

    // Low half on the rise, high half on the fall, strobe edge-aligned
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_o        <= 16'h0;
            dq_oe_o     <= 1'b0;
            hi_half_r   <= 16'h0;
            strobe_o    <= 1'b0;
            strobe_oe_o <= 1'b0;
        end else if (rise_x) begin
            if (rd_valid_i && clk_en_r) begin
                dq_o        <= rd_word_i[15:0];
                hi_half_r   <= rd_word_i[31:16];
                dq_oe_o     <= 1'b1;
                strobe_o    <= 1'b1;
                strobe_oe_o <= 1'b1;
            end else begin
                dq_oe_o     <= 1'b0;
                strobe_o    <= 1'b0;
                strobe_oe_o <= 1'b0;
            end
        end else if (fall_x && dq_oe_o) begin
            dq_o     <= hi_half_r;
            strobe_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== logic/cmd_capture_map.svh ====
`ifndef CMD_CAPTURE_MAP_SVH
`define CMD_CAPTURE_MAP_SVH

// ----------------------------------------------------------------
// Pin widths
// ----------------------------------------------------------------
`define ADDR_W          13
`define BANK_W          3
`define DQ_W            16
`define BYTE_W          8

// ----------------------------------------------------------------
// Positions of pins in the sampled pin vector
// ----------------------------------------------------------------
`define PIN_W           43
`define PIN_CK          0
`define PIN_CK_N        1
`define PIN_CS_N        2
`define PIN_RAS_N       3
`define PIN_CAS_N       4
`define PIN_WE_N        5
`define PIN_CKE         6
`define PIN_BA_LO       7
`define PIN_ADDR_LO     10
`define PIN_DQ_LO       23
`define PIN_LSTROBE     39
`define PIN_USTROBE     40
`define PIN_LMASK       41
`define PIN_UMASK       42

// ----------------------------------------------------------------
// Timing counts, in link clock periods
// ----------------------------------------------------------------
`define WR_WINDOW_CLKS  4'd8

// ----------------------------------------------------------------
// Buffer depth
// ----------------------------------------------------------------
`define BUF_DEPTH       2

`endif

// ==== logic/cmd_capture_pkg.sv ====
`default_nettype none

package cmd_capture_pkg;

    // One-hot command codes decoded from the strobe lines
    typedef enum logic [7:0] {
        CMD_NOP  = 8'h01,
        CMD_ACT  = 8'h02,
        CMD_RD   = 8'h04,
        CMD_WR   = 8'h08,
        CMD_PRE  = 8'h10,
        CMD_REF  = 8'h20,
        CMD_MRS  = 8'h40,
        CMD_RSVD = 8'h80
    } cmd_code_t;

    // A captured command with its bank and address
    typedef struct packed {
        cmd_code_t   code;
        logic [2:0]  bank;
        logic [12:0] addr;
    } cmd_word_t;

    // One captured write beat; a byte enable low means masked
    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  byte_en;
    } beat_t;

endpackage

`default_nettype wire

// ==== logic/pair_buffer.sv ====
`default_nettype none

`include "cmd_capture_map.svh"

module pair_buffer
    import cmd_capture_pkg::*;
(
    // Clock and reset
    input  wire logic  sys_clk_i,
    input  wire logic  rst_b_i,
    // Filling side
    input  wire logic  in_valid_i,
    output logic       in_ready_o,
    input  wire beat_t in_beat_i,
    // Draining side
    output logic       out_valid_o,
    input  wire logic  out_ready_i,
    output beat_t      out_beat_o
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    beat_t      mem_r [`BUF_DEPTH];  // Two entries
    logic       wr_ptr_r;            // Next slot to fill
    logic       rd_ptr_r;            // Next slot to drain
    logic [1:0] count_r;             // Entries held
    logic       push;                // Accepted write
    logic       pop;                 // Accepted read

    // Honest flags straight from the count
    assign in_ready_o  = (count_r != 2'd2);
    assign out_valid_o = (count_r != 2'd0);
    assign out_beat_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Entry write; no reset needed since valid gates every read
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_beat_i;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push && !pop) begin
                count_r <= count_r + 2'd1;
            end else if (pop && !push) begin
                count_r <= count_r - 2'd1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== testbench/ddr2_command_input_capture_properties.sv ====
`default_nettype none

// ----
// Port checker for the command capture block
// ----
module capture_chk
    import cmd_capture_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_b_i,
    // Pins
    input wire logic        cke_i,
    input wire logic        cs_n_i,
    input wire logic        ras_n_i,
    input wire logic        cas_n_i,
    input wire logic        we_n_i,
    input wire logic        lmask_i,
    input wire logic        umask_i,
    // Read side
    input wire logic        rd_valid_i,
    input wire logic [31:0] rd_word_i,
    input wire logic        rd_ready_o,
    input wire logic [15:0] dq_o,
    input wire logic        dq_oe_o,
    input wire logic        strobe_o,
    input wire logic        strobe_oe_o,
    // Streams
    input wire logic        cmd_valid_o,
    input wire cmd_word_t   cmd_o,
    input wire logic        clk_active_o,
    input wire logic        beat_valid_o,
    input wire beat_t       beat_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Code for each row, column, write pattern
    localparam cmd_code_t code_tbl [8] = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT,
                                           CMD_WR, CMD_RD, CMD_RSVD, CMD_NOP};
    logic [31:0] word_r;  // Word last taken for reading

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Keep the taken word so both halves can be compared later
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word_r <= '0;
        end else if (rd_ready_o && rd_valid_i) begin
            word_r <= rd_word_i;
        end
    end

    // Low half goes out first with the strobe high
    sequence s_rd_lo;
        dq_oe_o && strobe_oe_o && strobe_o && dq_o == word_r[15:0];
    endsequence
    // High half follows with the strobe low
    sequence s_rd_hi;
        dq_oe_o && !strobe_o && dq_o == word_r[31:16];
    endsequence

    // Pins stand still 4 cycles around the crossing, so depth 3 is safe
    a_cs_masks: assert property (cmd_valid_o |-> !$past(cs_n_i, 3))
        else $error("command while deselected");
    a_code_decode: assert property (cmd_valid_o |-> cmd_o.code ==
        code_tbl[{$past(ras_n_i, 3), $past(cas_n_i, 3), $past(we_n_i, 3)}])
        else $error("wrong command code");
    a_one_crossing: assert property (cmd_valid_o |=> !cmd_valid_o [*7])
        else $error("command on falling crossing");
    a_cmd_gated: assert property (cmd_valid_o |-> $past(clk_active_o))
        else $error("command while clocking off");
    a_cke_tracks: assert property ($changed(clk_active_o) |->
        clk_active_o == $past(cke_i, 3))
        else $error("clock enable state wrong");
    a_mask_drop: assert property (beat_valid_o |-> beat_o.byte_en != 2'b00)
        else $error("fully masked beat stored");
    a_lane_map: assert property ($rose(beat_valid_o) |->
        beat_o.byte_en == ~{$past(umask_i, 3), $past(lmask_i, 3)})
        else $error("lane enables do not follow masks");
    // Ready pulses on every rising crossing with clocks on; only a taken word is driven
    a_read_halves: assert property (rd_ready_o && rd_valid_i |=> s_rd_lo ##[2:6] s_rd_hi)
        else $error("read halves out of order");
endmodule

bind ddr2_command_input_capture capture_chk i_chk (
    .sys_clk_i, .rst_b_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i,
    .lmask_i, .umask_i, .rd_valid_i, .rd_word_i, .rd_ready_o, .dq_o, .dq_oe_o, .strobe_o,
    .strobe_oe_o, .cmd_valid_o, .cmd_o, .clk_active_o, .beat_valid_o, .beat_o
);

`default_nettype wire

// ==== testbench/ctrl_model.sv ====
`default_nettype none

// ----
// Memory controller model driving the pins
// ----
module ctrl_model (
    // Times pin changes
    input  wire logic  sys_clk_i,
    // Link clock pair and clock enable
    output logic        ck_o,
    output logic        ck_n_o,
    output logic        cke_o,
    // {select, row, column, write}, low active
    output logic [3:0]  cmd_n_o,
    // Bank and address
    output logic [2:0]  bank_o,
    output logic [12:0] addr_o,
    // Write data, strobes, masks
    output logic [15:0] dq_o,
    output logic [1:0]  dqs_o,
    output logic [1:0]  dm_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Free running link clock, phase unrelated to the system clock
    initial begin
        ck_o = 1'b0;
        ck_n_o = 1'b1;
        cke_o = 1'b0;
        cmd_n_o = 4'hf;  // Deselected at power up
        bank_o = '0;
        addr_o = '0;
        dq_o = 16'ha5c3;
        dqs_o = 2'b00;  // Strobes idle low
        dm_o = 2'b00;
        #7;
        forever begin
            #100;
            ck_o = ~ck_o;
            ck_n_o = ~ck_o;  // Complement mirrors the true leg, so they cross
        end
    end

    // Pins set early in the low phase so they stand across the rising crossing
    task automatic issue(input logic [3:0] c, input logic [2:0] b,
                         input logic [12:0] a, input logic e);
        @(negedge ck_o);
        @(negedge sys_clk_i);
        cmd_n_o = c;
        bank_o = b;
        addr_o = a;
        cke_o = e;
        @(negedge ck_o);
        @(negedge sys_clk_i);
        cmd_n_o = 4'hf;  // No stray command between requests
        bank_o = ~b;  // Hold time over: no stale value
        addr_o = ~a;
    endtask

    // Data and masks move with both strobes, one beat each
    task automatic beat(input logic [15:0] d, input logic [1:0] m);
        repeat (4) @(negedge sys_clk_i);
        dq_o = d;
        dm_o = m;
        dqs_o = ~dqs_o;
    endtask

    // Release data after a burst: show a changed value
    task automatic rest;
        repeat (4) @(negedge sys_clk_i);
        dq_o = ~dq_o;
    endtask
endmodule

`default_nettype wire

// ==== testbench/tb_ddr2_command_input_capture.sv ====
`default_nettype none

module tb_ddr2_command_input_capture
    import cmd_capture_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;

    // ----
    // Signals
    // ----
    localparam cmd_code_t code_tbl [8] = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT,
                                           CMD_WR, CMD_RD, CMD_RSVD, CMD_NOP};
    logic        sys_clk = 1'b0;  // 40 MHz
    logic        rst_b, ck, ck_n, cke, dq_oe, strobe, strobe_oe;
    logic        cmd_valid, clk_active, beat_valid, beat_ready, beat_room;
    logic        rd_valid, rd_ready;
    logic [3:0]  cmd_n;           // {select, row, column, write}
    logic [2:0]  bank;
    logic [12:0] addr;
    logic [15:0] m_dq, dq_o, dq_w;  // Model data, block data, wire
    logic [1:0]  m_dqs, dm;
    logic [31:0] rd_word;
    cmd_word_t   cmd, last_cmd;
    beat_t       beat;
    int          n_cmd = 0, fails = 0, cmp_count = 0;

    // Wire level from whichever side drives
    assign dq_w = dq_oe ? dq_o : m_dq;

    always #12.5 sys_clk = ~sys_clk;

    ctrl_model i_ctrl (.sys_clk_i(sys_clk), .ck_o(ck), .ck_n_o(ck_n), .cke_o(cke),
        .cmd_n_o(cmd_n), .bank_o(bank), .addr_o(addr), .dq_o(m_dq), .dqs_o(m_dqs),
        .dm_o(dm));

    ddr2_command_input_capture i_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
        .ck_i(ck), .ck_n_i(ck_n), .cke_i(cke), .cs_n_i(cmd_n[3]), .ras_n_i(cmd_n[2]),
        .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .bank_i(bank), .addr_i(addr),
        .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe),
        .lstrobe_i(strobe_oe ? strobe : m_dqs[0]), .ustrobe_i(strobe_oe ? strobe : m_dqs[1]),
        .strobe_o(strobe), .strobe_oe_o(strobe_oe), .lmask_i(dm[0]), .umask_i(dm[1]),
        .cmd_valid_o(cmd_valid), .cmd_o(cmd), .clk_active_o(clk_active),
        .beat_valid_o(beat_valid), .beat_ready_i(beat_ready), .beat_o(beat),
        .beat_room_o(beat_room), .rd_valid_i(rd_valid), .rd_ready_o(rd_ready),
        .rd_word_i(rd_word));

    // Count and keep every command the block hands out
    always @(posedge sys_clk) begin
        if (cmd_valid === 1'b1) begin
            last_cmd <= cmd;
            n_cmd <= n_cmd + 1;
        end
    end

    // ----
    // Tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One request; n is how many commands should come out
    task automatic cmd_chk(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
                           input logic e, input int n, input cmd_code_t code);
        int n0;
        n0 = n_cmd;
        i_ctrl.issue(c, b, a, e);
        repeat (4) @(negedge sys_clk);
        check(n_cmd - n0, n);
        if (n == 1) begin
            check(last_cmd, {code, b, a});
        end
    endtask

    // Take one buffered beat; only enabled lanes are compared
    task automatic pop(input logic [15:0] d, input logic [1:0] en);
        check(beat_valid, 1'b1);
        check(beat.byte_en, en);
        check(beat.data & {{8{en[1]}}, {8{en[0]}}}, d);
        beat_ready = 1'b1;
        @(negedge sys_clk);
        beat_ready = 1'b0;
        @(negedge sys_clk);
    endtask

    // Commands ignored until clock enable is registered high
    task automatic t_cke;
        cmd_chk(4'h3, 3'h5, 13'h0abc, 1'b0, 0, CMD_ACT);
        check(clk_active, 1'b0);
        cmd_chk(4'hf, 3'h0, 13'h0000, 1'b1, 0, CMD_NOP);
        check(clk_active, 1'b1);
    endtask

    // Every strobe pattern with select low, deselect last
    task automatic t_codes;
        for (int i = 0; i < 8; i++) begin
            cmd_chk({1'b0, i[2:0]}, i[2:0], 13'h1555 ^ 13'(i), 1'b1, 1, code_tbl[i]);
        end
        cmd_chk(4'hb, 3'h2, 13'h0f0f, 1'b1, 0, CMD_ACT);
    endtask

    // Masked beats with the receiver stalled, then drained
    task automatic t_write;
        cmd_chk(4'h4, 3'h1, 13'h0040, 1'b1, 1, CMD_WR);
        i_ctrl.beat(16'h1122, 2'b11);  // Both lanes masked
        i_ctrl.beat(16'h3344, 2'b10);
        i_ctrl.beat(16'h5566, 2'b01);
        repeat (4) @(negedge sys_clk);
        check(beat_room, 1'b0);
        i_ctrl.beat(16'h7788, 2'b00);  // No room: lost
        i_ctrl.rest;
        pop(16'h0044, 2'b01);
        pop(16'h5500, 2'b10);
        check(beat_valid, 1'b0);
    endtask

    // Two words back to back: low half on rise, high half on fall
    task automatic t_read;
        logic [31:0] w;
        for (int k = 0; k < 2; k++) begin
            w = k ? 32'h1234_abcd : 32'hfe01_7c38;
            rd_word = w;
            rd_valid = 1'b1;
            for (int t = 0; t < 40 && rd_ready !== 1'b1; t++) @(negedge sys_clk);
            check(rd_ready, 1'b1);
            @(negedge sys_clk);
            check({strobe_oe, dq_oe, strobe, dq_o}, {3'h7, w[15:0]});
            @(negedge ck);
            repeat (4) @(negedge sys_clk);
            check({dq_oe, strobe, dq_o}, {2'b10, w[31:16]});
        end
        rd_valid = 1'b0;
    endtask

    // ----
    // Sequence and watchdog
    // ----
    initial begin
        rst_b = 1'b0;
        beat_ready = 1'b0;
        rd_valid = 1'b0;
        rd_word = '0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({cmd_valid, clk_active, dq_oe, beat_valid}, 4'h0);
        check(cmd.code, CMD_NOP);
        t_cke;
        t_codes;
        t_write;
        t_read;
        close_out;
    end

    // Whole run needs about 6 us; a hang is cut well after that
    initial begin
        #200000;
        fails++;
        close_out;
    end
endmodule

`default_nettype wire
